// [hw/spibuf_link.sv]
// Link-clock capture of received bytes and start address, toggle handoff
`timescale 1ns/1ns
module spibuf_link
    import spibuf_pkg::*;
(
    input  wire logic       i_link_clk,
    input  wire logic       i_rst,
    input  wire logic       i_byte_stb,
    input  wire logic [7:0] i_rx_byte,
    input  wire logic       i_addr_stb,
    input  wire logic [7:0] i_addr,
    output logic      [7:0] o_rx_hold,
    output logic      [5:0] o_addr_hold,
    output logic            o_byte_tog,
    output logic            o_addr_tog
);
    logic [7:0] rx_hold_d;
    logic [5:0] addr_hold_d;
    logic       byte_tog_d;
    logic       addr_tog_d;

    // Holds stay still from toggle to toggle, so the core may sample them late
    always_comb begin
        rx_hold_d   = o_rx_hold;
        addr_hold_d = o_addr_hold;
        byte_tog_d  = o_byte_tog;
        addr_tog_d  = o_addr_tog;
        if (i_byte_stb) begin
            rx_hold_d  = i_rx_byte;
            byte_tog_d = ~o_byte_tog;
        end
        if (i_addr_stb) begin
            addr_hold_d = i_addr[5:0]; // [R12]
            addr_tog_d  = ~o_addr_tog;
        end
    end

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_hold   <= 8'h00;
            o_addr_hold <= ADDR_RST;
            o_byte_tog  <= 1'b0;
            o_addr_tog  <= 1'b0;
        end else begin
            o_rx_hold   <= rx_hold_d;
            o_addr_hold <= addr_hold_d;
            o_byte_tog  <= byte_tog_d;
            o_addr_tog  <= addr_tog_d;
        end
    end
endmodule : spibuf_link

// [hw/spibuf_pkg.sv]
// Constants, register map and state type of the SPI CPU data buffer
package spibuf_pkg;
    localparam int          NUM_WORDS      = 16;
    localparam logic [7:0]  OFF_WORD0      = 8'h00;
    localparam logic [7:0]  OFF_CTRL       = 8'h40;
    localparam logic [7:0]  OFF_STAT       = 8'h44;
    localparam logic [1:0]  WORD_REGION    = 2'h0;
    localparam int          CTRL_TXU_BIT   = 0;
    localparam int          CTRL_RXU_BIT   = 1;
    localparam int          CTRL_SLAVE_BIT = 2;
    localparam int          CTRL_HALF_BIT  = 3;
    localparam int          CTRL_TXDMA_BIT = 4;
    localparam int          CTRL_RXDMA_BIT = 5;
    localparam int          CTRL_START_BIT = 8;
    localparam int          CTRL_W         = 6;
    localparam logic [5:0]  CTRL_RST       = 6'h00;
    localparam int          STAT_BUSY_BIT  = 0;
    localparam int          STAT_ARM_BIT   = 1;
    localparam int          STAT_CNT_LSB   = 8;
    localparam int          STAT_ADDR_LSB  = 16;
    localparam logic [7:0]  LOWER_LEN      = 8'h40;
    localparam logic [7:0]  UPPER_LEN      = 8'h20;
    localparam logic [5:0]  TOP_BYTE_ADDR  = 6'h3f;
    localparam logic [5:0]  UPPER_BASE     = 6'h20;
    localparam logic [7:0]  CNT_RST        = 8'h00;
    localparam logic [5:0]  ADDR_RST       = 6'h00;
    localparam logic [31:0] WORD_RST       = 32'h0000_0000;
    localparam logic [7:0]  TX_DMA_FILL    = 8'h00;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ARMED  = 2'b01,
        ST_ACTIVE = 2'b10
    } spibuf_state_t;
endpackage : spibuf_pkg

// [hw/spibuf_top.sv]
// SPI CPU-mode data buffer: sixteen words, byte addressing, AHB-Lite slave
//
// Operation
// [R1] Sixteen 32-bit words, byte addresses 0 to 63
// [R2] Software configures, then triggers each single transaction
// [R3] Works master or slave, full or half duplex
// [R4] CPU single transfer supported in both roles
// [R5] Master TX low: 0-63, then top byte repeats
// [R6] Master TX high: words 8-15, then top byte repeats
// [R7] Master RX low: 0-63, then overwrite top byte
// [R8] Master RX high: words 8-15, then overwrite top byte
// [R9] Separate upper-half selects for transmit and receive
// [R10] Address 0 is base word bits 7:0
// [R11] Slave full duplex: start 0, lower wrap
// [R12] Slave half duplex: master gives start address
// [R13] Direction with DMA enabled leaves buffer alone
// [R14] Word from address bits 5:2, lane 1:0
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
module spibuf_top
    import spibuf_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_LINK_CLK,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic             O_HREADYOUT,
    output logic      [31:0] O_HRDATA,
    output logic             O_HRESP,
    input  wire logic        I_LINK_FRAME,
    input  wire logic        I_LINK_BYTE_STB,
    input  wire logic [7:0]  I_LINK_RX_BYTE,
    input  wire logic        I_LINK_ADDR_STB,
    input  wire logic [7:0]  I_LINK_ADDR,
    output logic      [7:0]  O_LINK_TX_BYTE,
    output logic             O_XFER_REQ
);
    logic [31:0]         mem_q [NUM_WORDS];
    logic [7:0]          rx_hold;
    logic [5:0]          addr_hold;
    logic                byte_tog;
    logic                addr_tog;
    logic [2:0]          s1_q, s2_q, s3_q, lvl_q, lvl_d;
    logic                byte_evt, addr_evt, frame_lvl;
    spibuf_state_t       st_q, st_d;
    logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
    logic [7:0]          cnt_q, cnt_d;
    logic [5:0]          hd_addr_q, hd_addr_d;
    logic                tx_load_q, tx_load_d;
    logic [7:0]          tx_byte_d;
    logic                xreq_d;
    logic                ap_wr_q, ap_wr_d, ap_rd_q, ap_rd_d;
    logic [7:0]          ap_addr_q, ap_addr_d;
    logic                ready_d;
    logic [31:0]         rdata_d;
    logic                acc, bus_wr, ctrl_wr, start_go, busy, slave, half;
    logic [5:0]          rx_addr, tx_addr;
    logic                rx_we;
    logic [7:0]          tx_pick;

    spibuf_link u_link (
        .i_link_clk  (I_LINK_CLK),
        .i_rst       (I_RST),
        .i_byte_stb  (I_LINK_BYTE_STB),
        .i_rx_byte   (I_LINK_RX_BYTE),
        .i_addr_stb  (I_LINK_ADDR_STB),
        .i_addr      (I_LINK_ADDR),
        .o_rx_hold   (rx_hold),
        .o_addr_hold (addr_hold),
        .o_byte_tog  (byte_tog),
        .o_addr_tog  (addr_tog)
    );

    // Byte address within the region for a given count of the 256-byte cycle
    function automatic logic [5:0] region_addr(input logic [7:0] cnt, input logic upper);
        if (upper) begin
            region_addr = (cnt < UPPER_LEN) ? (UPPER_BASE | {1'b0, cnt[4:0]})
                                            : TOP_BYTE_ADDR; // [R6] [R8]
        end else begin
            region_addr = (cnt < LOWER_LEN) ? cnt[5:0] : TOP_BYTE_ADDR; // [R5] [R7]
        end
    endfunction : region_addr

    function automatic logic [7:0] byte_at(input logic [5:0] a, input logic [31:0] w);
        byte_at = w[{a[1:0], 3'b000} +: 8]; // [R10] [R14]
    endfunction : byte_at

    // Three-stage capture; a change counts once stages two and three agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            s1_q  <= 3'h0;
            s2_q  <= 3'h0;
            s3_q  <= 3'h0;
            lvl_q <= 3'h0;
        end else begin
            s1_q  <= {addr_tog, byte_tog, I_LINK_FRAME};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign frame_lvl = lvl_q[0];
    assign byte_evt  = (lvl_d[1] ^ lvl_q[1]) && busy;
    assign addr_evt  = (lvl_d[2] ^ lvl_q[2]) && busy && slave && half;

    assign slave = ctrl_q[CTRL_SLAVE_BIT];
    assign half  = ctrl_q[CTRL_HALF_BIT];
    assign busy  = (st_q != ST_IDLE);

    // Slave modes ignore the upper-half selects, the half-duplex wrap included
    always_comb begin
        if (slave && half) begin
            rx_addr = hd_addr_q; // [R12]
            tx_addr = hd_addr_q; // [R12]
        end else if (slave) begin
            rx_addr = region_addr(cnt_q, 1'b0); // [R11]
            tx_addr = region_addr(cnt_q, 1'b0); // [R11]
        end else begin
            rx_addr = region_addr(cnt_q, ctrl_q[CTRL_RXU_BIT]); // [R9] [R3]
            tx_addr = region_addr(cnt_q, ctrl_q[CTRL_TXU_BIT]); // [R9] [R3]
        end
    end

    assign rx_we   = byte_evt && !ctrl_q[CTRL_RXDMA_BIT]; // [R13]
    assign tx_pick = byte_at(tx_addr, mem_q[tx_addr[5:2]]); // [R14]

    // AHB-Lite address phase; only whole-word writes take effect, reads of any size are taken
    assign acc     = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign bus_wr  = ap_wr_q;
    assign ctrl_wr = bus_wr && (ap_addr_q == OFF_CTRL);
    assign start_go = ctrl_wr && I_HWDATA[CTRL_START_BIT] && !busy; // [R2] [R4]

    // Buffer words; receive lane write lands after a bus write to the same word
    for (genvar g = 0; g < NUM_WORDS; g++) begin : g_word
        logic [31:0] word_d;
        always_comb begin
            word_d = mem_q[g];
            if (bus_wr && ap_addr_q[7:6] == WORD_REGION && ap_addr_q[5:2] == 4'(g)) begin
                word_d = I_HWDATA; // [R1]
            end
            if (rx_we && rx_addr[5:2] == 4'(g)) begin
                word_d[{rx_addr[1:0], 3'b000} +: 8] = rx_hold; // [R10] [R14]
            end
        end
        always_ff @(posedge I_CLK or posedge I_RST) begin
            if (I_RST) begin
                mem_q[g] <= WORD_RST;
            end else begin
                mem_q[g] <= word_d;
            end
        end
    end

    // Transaction control
    always_comb begin
        st_d      = st_q;
        ctrl_d    = ctrl_q;
        cnt_d     = cnt_q;
        hd_addr_d = hd_addr_q;
        tx_load_d = 1'b0;
        tx_byte_d = O_LINK_TX_BYTE;
        // Mode bits are frozen while a transaction is armed or running
        if (ctrl_wr && !busy) begin
            ctrl_d = I_HWDATA[CTRL_W-1:0];
        end
        unique case (st_q)
            ST_IDLE: begin
                if (start_go) begin
                    st_d      = ST_ARMED; // [R2]
                    cnt_d     = CNT_RST; // [R11]
                    hd_addr_d = ADDR_RST;
                    tx_load_d = 1'b1;
                end
            end
            ST_ARMED: begin
                if (frame_lvl) begin
                    st_d = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (!frame_lvl) begin
                    st_d = ST_IDLE; // [R2]
                end
            end
        endcase
        if (addr_evt) begin
            hd_addr_d = addr_hold; // [R12]
            tx_load_d = 1'b1;
        end else if (byte_evt) begin
            cnt_d     = 8'(cnt_q + 8'h01);
            tx_load_d = 1'b1;
            if (slave && half) begin
                hd_addr_d = (hd_addr_q == TOP_BYTE_ADDR) ? UPPER_BASE
                                                         : 6'(hd_addr_q + 6'h01); // [R12]
            end
        end
        // Next byte fetched a cycle late so it sees the byte just received
        if (tx_load_q) begin
            tx_byte_d = ctrl_q[CTRL_TXDMA_BIT] ? TX_DMA_FILL : tx_pick; // [R13]
        end
    end

    assign xreq_d = (st_d != ST_IDLE) && !ctrl_d[CTRL_SLAVE_BIT];

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            st_q           <= ST_IDLE;
            ctrl_q         <= CTRL_RST;
            cnt_q          <= CNT_RST;
            hd_addr_q      <= ADDR_RST;
            tx_load_q      <= 1'b0;
            O_LINK_TX_BYTE <= 8'h00;
            O_XFER_REQ     <= 1'b0;
        end else begin
            st_q           <= st_d;
            ctrl_q         <= ctrl_d;
            cnt_q          <= cnt_d;
            hd_addr_q      <= hd_addr_d;
            tx_load_q      <= tx_load_d;
            O_LINK_TX_BYTE <= tx_byte_d;
            O_XFER_REQ     <= xreq_d;
        end
    end

    // Bus slave: writes without wait, reads with one wait state so read data
    // already includes a write taken at the same edge
    always_comb begin
        ap_wr_d   = acc && I_HWRITE && (I_HSIZE == HSIZE_WORD);
        ap_rd_d   = acc && !I_HWRITE;
        ap_addr_d = acc ? I_HADDR[7:0] : ap_addr_q;
        ready_d   = !ap_rd_d;
        rdata_d   = O_HRDATA;
        if (ap_rd_q) begin
            rdata_d = 32'h0000_0000;
            if (ap_addr_q[7:6] == WORD_REGION && ap_addr_q[1:0] == 2'h0) begin
                rdata_d = mem_q[ap_addr_q[5:2]];
            end else if (ap_addr_q == OFF_CTRL) begin
                rdata_d[CTRL_W-1:0] = ctrl_q;
            end else if (ap_addr_q == OFF_STAT) begin
                rdata_d[STAT_BUSY_BIT]             = busy;
                rdata_d[STAT_ARM_BIT]              = (st_q == ST_ARMED);
                rdata_d[STAT_CNT_LSB +: 8]         = cnt_q;
                rdata_d[STAT_ADDR_LSB +: 6]        = hd_addr_q;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            ap_wr_q     <= 1'b0;
            ap_rd_q     <= 1'b0;
            ap_addr_q   <= 8'h00;
            O_HREADYOUT <= 1'b1;
            O_HRDATA    <= 32'h0000_0000;
            O_HRESP     <= 1'b0;
        end else begin
            ap_wr_q     <= ap_wr_d;
            ap_rd_q     <= ap_rd_d;
            ap_addr_q   <= ap_addr_d;
            O_HREADYOUT <= ready_d;
            O_HRDATA    <= rdata_d;
            O_HRESP     <= 1'b0;
        end
    end

    // Checking helpers
    logic        chk_we_q;
    logic [5:0]  chk_addr_q;
    logic [7:0]  chk_byte_q;
    logic [31:0] chk_word_q;
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            chk_we_q   <= 1'b0;
            chk_addr_q <= 6'h00;
            chk_byte_q <= 8'h00;
            chk_word_q <= WORD_RST;
        end else begin
            chk_we_q   <= rx_we;
            chk_addr_q <= rx_addr;
            chk_byte_q <= rx_hold;
            chk_word_q <= mem_q[rx_addr[5:2]];
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    read_wait_a: assert property (acc && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
        else $error("read wait state wrong");
    start_arm_a: assert property (start_go |=> st_q == ST_ARMED && cnt_q == 8'h00) // [R2]
        else $error("start did not arm a fresh transaction");
    rx_low_map_a: assert property (rx_we && !slave && !ctrl_q[CTRL_RXU_BIT] // [R7]
        |-> rx_addr == ((cnt_q < 8'h40) ? cnt_q[5:0] : 6'h3f))
        else $error("lower receive address wrong");
    rx_high_map_a: assert property (rx_we && !slave && ctrl_q[CTRL_RXU_BIT] // [R8]
        |-> rx_addr == ((cnt_q < 8'h20) ? (6'h20 + cnt_q[5:0]) : 6'h3f))
        else $error("upper receive address wrong");
    tx_low_map_a: assert property (tx_load_q && !slave && !ctrl_q[CTRL_TXU_BIT] // [R5]
        |-> tx_addr == ((cnt_q < 8'h40) ? cnt_q[5:0] : 6'h3f))
        else $error("lower transmit address wrong");
    tx_high_data_a: assert property (tx_load_q && !ctrl_q[CTRL_TXDMA_BIT] // [R6]
        |=> O_LINK_TX_BYTE == $past(tx_pick))
        else $error("transmit byte not taken from buffer");
    slave_fd_a: assert property (byte_evt && slave && !half && cnt_q == 8'h3f // [R11]
        |=> cnt_q == 8'h40 && rx_addr == 6'h3f)
        else $error("slave full duplex wrap wrong");
    hd_wrap_a: assert property (byte_evt && slave && half && hd_addr_q == 6'h3f // [R12]
        |=> hd_addr_q == 6'h20)
        else $error("half duplex wrap not to word 8");
    dma_gate_a: assert property (byte_evt && ctrl_q[CTRL_RXDMA_BIT] && !bus_wr // [R13]
        |=> mem_q[chk_addr_q[5:2]] == chk_word_q)
        else $error("buffer written with DMA receive enabled");
    lane_map_a: assert property (chk_we_q // [R10]
        |-> mem_q[chk_addr_q[5:2]][{chk_addr_q[1:0], 3'b000} +: 8] == chk_byte_q)
        else $error("received byte in wrong lane");
    tx_high_map_a: assert property (tx_load_q && !slave && ctrl_q[CTRL_TXU_BIT] // [R6]
        |-> tx_addr == ((cnt_q < 8'h20) ? (6'h20 + cnt_q[5:0]) : 6'h3f))
        else $error("upper transmit address wrong");
    tx_fill_a: assert property (tx_load_q && ctrl_q[CTRL_TXDMA_BIT] // [R13]
        |=> O_LINK_TX_BYTE == TX_DMA_FILL)
        else $error("transmit byte not filled with DMA transmit enabled");
    hd_start_a: assert property (addr_evt |=> hd_addr_q == $past(addr_hold)) // [R12]
        else $error("half duplex start address not taken");
    frame_end_a: assert property (st_q == ST_ACTIVE && !frame_lvl // [R2]
        |=> st_q == ST_IDLE && !O_XFER_REQ)
        else $error("transaction did not end with the frame");

    low_wrap_c: cover property (byte_evt && !slave && cnt_q == 8'hff);
    high_rep_c: cover property (rx_we && ctrl_q[CTRL_RXU_BIT] && cnt_q == 8'h20);
    hd_wrap_c:  cover property (byte_evt && slave && half && hd_addr_q == 6'h3f);
    read_c:     cover property (ap_rd_q && ap_addr_q == OFF_STAT);
endmodule : spibuf_top

// [verification/spibuf_peer.sv]
// SPI peer model: gated link clock, byte and start-address strobes
`timescale 1ns/1ns
module spibuf_peer (
    output logic            o_link_clk,
    output logic            o_frame,
    output logic            o_byte_stb,
    output logic      [7:0] o_rx_byte,
    output logic            o_addr_stb,
    output logic      [7:0] o_addr,
    input  wire logic [7:0] i_tx_byte
);
    logic [7:0] tx_seen [0:511];

    initial begin
        o_link_clk = 1'b0;
        o_frame    = 1'b0;
        o_byte_stb = 1'b0;
        o_addr_stb = 1'b0;
        o_rx_byte  = 8'h00;
        o_addr     = 8'h00;
    end

    // Clock stands still between frames; released data lines toggle
    task automatic tick(input logic stb, input logic ad, input logic [7:0] d);
        o_byte_stb = stb;
        o_addr_stb = ad;
        o_rx_byte  = stb ? d : ~o_rx_byte;
        o_addr     = ad ? d : ~o_addr;
        #24 o_link_clk = 1'b1;
        #24 o_link_clk = 1'b0;
    endtask : tick

    // One frame carries exactly one transaction
    task automatic run(input int n, input logic hd, input logic [7:0] sa, input logic [7:0] seed);
        #7;
        o_frame = 1'b1;
        repeat (2) tick(1'b0, 1'b0, 8'h00);
        if (hd) begin
            repeat (7) tick(1'b0, 1'b0, 8'h00);
            tick(1'b0, 1'b1, sa);
        end
        for (int k = 0; k < n; k++) begin
            for (int c = 1; c <= 8; c++) begin
                // Load at the fourth of eight clocks of the byte, well after the core has settled
                if (c == 4) tx_seen[k] = i_tx_byte;
                tick(c == 8, 1'b0, seed + 8'(k));
            end
        end
        repeat (2) tick(1'b0, 1'b0, 8'h00);
        o_frame = 1'b0;
    endtask : run
endmodule : spibuf_peer

// [verification/spibuf_top_tb.sv]
// Testbench for the SPI CPU data buffer: bus tasks, peer frames, buffer model
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module spibuf_top_tb
    import spibuf_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        hsel;
    logic        hwrite;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic        lclk;
    logic        frame;
    logic        bstb;
    logic        astb;
    logic        xreq;
    logic [7:0]  rxb;
    logic [7:0]  adr;
    logic [7:0]  txb;
    logic [7:0]  mem [0:63];
    int          bad_count;
    int          tests_run;
    // Modes: master, master half+upper tx, upper rx, slave with selects, slave half, DMA
    logic [5:0]  md [0:5] = '{6'h00, 6'h09, 6'h02, 6'h07, 6'h0c, 6'h38};
    int          nb [0:5] = '{260, 40, 40, 70, 10, 6};

    spibuf_top spibuf_top_inst (
        .I_CLK(clk), .I_RST(rst), .I_LINK_CLK(lclk), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp),
        .I_LINK_FRAME(frame), .I_LINK_BYTE_STB(bstb), .I_LINK_RX_BYTE(rxb),
        .I_LINK_ADDR_STB(astb), .I_LINK_ADDR(adr), .O_LINK_TX_BYTE(txb), .O_XFER_REQ(xreq)
    );

    spibuf_peer spibuf_peer_inst (
        .o_link_clk(lclk), .o_frame(frame), .o_byte_stb(bstb), .o_rx_byte(rxb),
        .o_addr_stb(astb), .o_addr(adr), .i_tx_byte(txb)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_of_test();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // Single word transfer; waits on the slave's ready, no fixed latency
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        `CHK("response", 1'b0, hresp)
    endtask : ahb

    // Byte address of byte k of a transaction in mode m
    function automatic int addr_of(input int k, input logic up, input logic [5:0] m);
        int a;
        int c;
        if (m[CTRL_SLAVE_BIT] && m[CTRL_HALF_BIT]) begin
            a = 60;
            for (int i = 0; i < k; i++) a = (a == 63) ? 32 : a + 1;
            return a;
        end
        c = k % 256;
        if (m[CTRL_SLAVE_BIT]) up = 1'b0;
        if (up) return (c < 32) ? 32 + c : 63;
        return (c < 64) ? c : 63;
    endfunction : addr_of

    initial begin
        #(64000 * 4);
        bad_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        logic [5:0]  m;
        logic [7:0]  seed;
        logic [7:0]  ex;
        int          ta;
        int          ra;
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = HSIZE_WORD;
        haddr = 32'h0;
        hwdata = 32'h0;
        bad_count = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        ahb(1'b0, OFF_CTRL, 32'h0, r);
        `CHK("ctrl reset", {26'h0, CTRL_RST}, r)
        ahb(1'b0, 8'h80, 32'h0, r);
        `CHK("unmapped", 32'h0, r)
        for (int t = 0; t < 6; t++) begin
            m = md[t];
            seed = 8'h80 + 8'(t * 17);
            for (int b = 0; b < 64; b++) mem[b] = 8'(b * 7 + t * 16 + 1);
            for (int w = 0; w < 16; w++) begin
                ahb(1'b1, 8'(w * 4), {mem[4*w+3], mem[4*w+2], mem[4*w+1], mem[4*w]}, r);
            end
            ahb(1'b1, OFF_CTRL, {23'h0, 1'b1, 2'h0, m}, r);
            if (!m[CTRL_SLAVE_BIT]) while (xreq !== 1'b1) @(posedge clk);
            repeat (2) @(posedge clk);
            `CHK("start request", !m[CTRL_SLAVE_BIT], xreq)
            ahb(1'b1, OFF_CTRL, {23'h0, 1'b1, 2'h0, ~m}, r);
            ahb(1'b0, OFF_STAT, 32'h0, r);
            `CHK("armed", 2'h3, r[STAT_ARM_BIT:STAT_BUSY_BIT])
            spibuf_peer_inst.run(nb[t], m[CTRL_SLAVE_BIT] & m[CTRL_HALF_BIT], 8'h3c, seed);
            for (int k = 0; k < nb[t]; k++) begin
                ta = addr_of(k, m[CTRL_TXU_BIT], m);
                ra = addr_of(k, m[CTRL_RXU_BIT], m);
                ex = m[CTRL_TXDMA_BIT] ? TX_DMA_FILL : mem[ta];
                `CHK("tx byte", ex, spibuf_peer_inst.tx_seen[k])
                if (!m[CTRL_RXDMA_BIT]) mem[ra] = seed + 8'(k);
            end
            repeat (12) @(posedge clk);
            `CHK("request after frame", 1'b0, xreq)
            ahb(1'b0, OFF_CTRL, 32'h0, r);
            `CHK("ctrl", {26'h0, m}, r)
            ahb(1'b0, OFF_STAT, 32'h0, r);
            `CHK("busy", 1'b0, r[STAT_BUSY_BIT])
            `CHK("count", 8'(nb[t]), r[STAT_CNT_LSB +: 8])
            for (int w = 0; w < 16; w++) begin
                ahb(1'b0, 8'(w * 4), 32'h0, r);
                `CHK("word", {mem[4*w+3], mem[4*w+2], mem[4*w+1], mem[4*w]}, r)
            end
        end
        end_of_test();
    end
endmodule : spibuf_top_tb
